// ### common/sbs_pkg.sv
// Purpose: constants for the switch and bridge status register bank
// Assumes: 16-bit registers, 7-bit register addresses
// Notes:   reset values are all zero
package sbs_pkg;
   localparam int          SBS_DATA_W       = 16;
   localparam int          SBS_ADDR_W       = 7;
   localparam int          SBS_NUM_CH       = 4;
   localparam logic [6:0]  SBS_ADDR_HS_FLT  = 7'h46;
   localparam logic [6:0]  SBS_ADDR_GEN     = 7'h50;
   localparam logic [15:0] SBS_RST_HS_FLT   = 16'h0000;
   localparam logic [15:0] SBS_RST_GEN      = 16'h0000;
   localparam int          SBS_OT_LSB       = 10;
   localparam int          SBS_OL_LSB       = 5;
   localparam int          SBS_OC_LSB       = 0;
   localparam int          SBS_VOUT_LSB     = 6;
   localparam int          SBS_PWM_LSB      = 0;
   localparam logic [1:0]  SBS_MODE_ACTIVE  = 2'h3;
endpackage

// ### hdl/sbs_sticky_flag.sv
// Purpose: one sticky fault flag, set by an event, cleared by a read
// Assumes: event and read strobe are synchronous to clk_sys_i
// Notes:   a set in the clearing cycle wins
`timescale 1ns/10ps
module sbs_sticky_flag (
   input  wire logic clk_sys_i,
   input  wire logic resetn_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      flag_o
);
   typedef struct packed {
      logic flag;
   } sbs_flag_state_t;

   sbs_flag_state_t state_r;
   sbs_flag_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      if (set_i) begin
         state_nxt.flag = 1'b1;
      end else if (clr_i) begin
         state_nxt.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign flag_o = state_r.flag;
endmodule

// ### hdl/sbs_status_regs.sv
// Purpose: high-side fault status and bridge general status registers
// Assumes: read strobe is one cycle per register read, data valid next cycle
// Notes:   fault inputs are one-cycle or level events, all synchronous
`timescale 1ns/10ps
// Functional notes
// [R1] sticky overtemp flags, switches 4..1 in bits 13..10, read clears
// [R2] sticky open-load flags, switches 4..1 in bits 8..5, cleared on read
// [R3] sticky overcurrent flags, switches 4..1 in bits 3..0, cleared on read
// [R4] reserved bits of both registers always read as zero
// [R5] bridge level bits 9..6 high when output near supply, mode 11, pump on
// [R6] bridge level bit forced low if pump off or mode not 11
// [R7] bits 3..0 of general status mirror PWM inputs 4..1
module sbs_status_regs
   import sbs_pkg::*;
(
   input  wire logic                  clk_sys_i,
   input  wire logic                  resetn_i,
   input  wire logic                  rd_en_i,
   input  wire logic [SBS_ADDR_W-1:0] rd_addr_i,
   output logic      [SBS_DATA_W-1:0] rd_data_o,
   output logic                       rd_hit_o,
   input  wire logic [SBS_NUM_CH-1:0] overtemp_evt_i,
   input  wire logic [SBS_NUM_CH-1:0] openload_evt_i,
   input  wire logic [SBS_NUM_CH-1:0] overcurrent_evt_i,
   input  wire logic [SBS_NUM_CH-1:0] bridge_near_supply_i,
   input  wire logic [7:0]            bridge_mode_field_i,
   input  wire logic                  charge_pump_enable_i,
   input  wire logic [SBS_NUM_CH-1:0] pwm_input_level_i,
   output logic      [SBS_NUM_CH-1:0] switch_overtemp_flag_o,
   output logic      [SBS_NUM_CH-1:0] switch_openload_flag_o,
   output logic      [SBS_NUM_CH-1:0] switch_overcurrent_flag_o
);
   typedef struct packed {
      logic [SBS_DATA_W-1:0] rd_data;
      logic                  rd_hit;
   } sbs_regs_state_t;

   sbs_regs_state_t           state_r;
   sbs_regs_state_t           state_nxt;
   logic                      rd_fault;
   logic [SBS_NUM_CH-1:0]     ot_flag;
   logic [SBS_NUM_CH-1:0]     ol_flag;
   logic [SBS_NUM_CH-1:0]     oc_flag;
   logic [SBS_NUM_CH-1:0]     bridge_output_level;
   logic [SBS_DATA_W-1:0]     fault_word;
   logic [SBS_DATA_W-1:0]     gen_word;

   assign rd_fault = rd_en_i && (rd_addr_i == SBS_ADDR_HS_FLT);

   genvar ch;
   generate
      for (ch = 0; ch < SBS_NUM_CH; ch++) begin : g_ch
         // [R1] overtemp sticky flag
         sbs_sticky_flag u_ot (
            .clk_sys_i (clk_sys_i),
            .resetn_i  (resetn_i),
            .set_i     (overtemp_evt_i[ch]),
            .clr_i     (rd_fault),
            .flag_o    (ot_flag[ch])
         );
         // [R2] open-load sticky flag
         sbs_sticky_flag u_ol (
            .clk_sys_i (clk_sys_i),
            .resetn_i  (resetn_i),
            .set_i     (openload_evt_i[ch]),
            .clr_i     (rd_fault),
            .flag_o    (ol_flag[ch])
         );
         // [R3] overcurrent sticky flag
         sbs_sticky_flag u_oc (
            .clk_sys_i (clk_sys_i),
            .resetn_i  (resetn_i),
            .set_i     (overcurrent_evt_i[ch]),
            .clr_i     (rd_fault),
            .flag_o    (oc_flag[ch])
         );
         // [R5] [R6] qualified output level
         assign bridge_output_level[ch] = charge_pump_enable_i
            && (bridge_mode_field_i[2*ch +: 2] == SBS_MODE_ACTIVE)
            && bridge_near_supply_i[ch];
      end
   endgenerate

   always_comb begin
      // [R4] reserved bits zero
      fault_word = SBS_RST_HS_FLT;
      gen_word   = SBS_RST_GEN;
      // [R1] overtemp field
      fault_word[SBS_OT_LSB +: SBS_NUM_CH] = ot_flag;
      // [R2] open-load field
      fault_word[SBS_OL_LSB +: SBS_NUM_CH] = ol_flag;
      // [R3] overcurrent field
      fault_word[SBS_OC_LSB +: SBS_NUM_CH] = oc_flag;
      // [R5] level field
      gen_word[SBS_VOUT_LSB +: SBS_NUM_CH] = bridge_output_level;
      // [R7] pwm mirror
      gen_word[SBS_PWM_LSB +: SBS_NUM_CH] = pwm_input_level_i;
   end

   always_comb begin
      state_nxt = state_r;
      state_nxt.rd_hit = 1'b0;
      if (rd_en_i) begin
         if (rd_addr_i == SBS_ADDR_HS_FLT) begin
            state_nxt.rd_data = fault_word;
            state_nxt.rd_hit  = 1'b1;
         end else if (rd_addr_i == SBS_ADDR_GEN) begin
            state_nxt.rd_data = gen_word;
            state_nxt.rd_hit  = 1'b1;
         end else begin
            state_nxt.rd_data = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rd_data_o                 = state_r.rd_data;
   assign rd_hit_o                  = state_r.rd_hit;
   assign switch_overtemp_flag_o    = ot_flag;
   assign switch_openload_flag_o    = ol_flag;
   assign switch_overcurrent_flag_o = oc_flag;
endmodule

// ### dv/sbs_status_monitor.sv
// Purpose: port checks; Assumes: read answer one cycle after request
// Notes: bound to sbs_status_regs
`timescale 1ns/10ps
module sbs_status_monitor import sbs_pkg::*; (
   input logic        clk_sys_i,
   input logic        resetn_i,
   input logic        rd_en_i,
   input logic [6:0]  rd_addr_i,
   input logic [15:0] rd_data_o,
   input logic        rd_hit_o,
   input logic [3:0]  overtemp_evt_i,
   input logic [3:0]  openload_evt_i,
   input logic [3:0]  overcurrent_evt_i,
   input logic [3:0]  bridge_near_supply_i,
   input logic [7:0]  bridge_mode_field_i,
   input logic        charge_pump_enable_i,
   input logic [3:0]  pwm_input_level_i
);
   wire        f = rd_en_i && rd_addr_i == SBS_ADDR_HS_FLT;
   wire        g = rd_en_i && rd_addr_i == SBS_ADDR_GEN;
   wire [15:0] d = rd_data_o;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   property p_ot; f ##1 f |=> d[13:10] == $past(overtemp_evt_i, 2); endproperty
   a_ot: assert property (p_ot) else $error("ot bits");
   property p_ol; f ##1 f |=> d[8:5] == $past(openload_evt_i, 2); endproperty
   a_ol: assert property (p_ol) else $error("ol bits");
   property p_oc; f ##1 f |=> d[3:0] == $past(overcurrent_evt_i, 2);
   endproperty
   a_oc: assert property (p_oc) else $error("oc bits");
   property p_rs; f |=> d[15:14] == 2'h0 && !d[9] && !d[4]; endproperty
   a_rs: assert property (p_rs) else $error("reserved");
   property p_rg; g |=> d[15:10] == 6'h00 && d[5:4] == 2'h0; endproperty
   a_rg: assert property (p_rg) else $error("reserved gen");
   property p_hit; f || g |=> rd_hit_o; endproperty
   a_hit: assert property (p_hit) else $error("hit");
   property p_miss; !(f || g) |=> !rd_hit_o; endproperty
   a_miss: assert property (p_miss) else $error("no hit");
   property p_lv; g && charge_pump_enable_i && bridge_mode_field_i == 8'hFF
      |=> d[9:6] == $past(bridge_near_supply_i); endproperty
   a_lv: assert property (p_lv) else $error("level");
   property p_of; g && (!charge_pump_enable_i || bridge_mode_field_i == 8'h00)
      |=> d[9:6] == 4'h0; endproperty
   a_of: assert property (p_of) else $error("level off");
   property p_pw; g |=> d[3:0] == $past(pwm_input_level_i); endproperty
   a_pw: assert property (p_pw) else $error("pwm");
endmodule
bind sbs_status_regs sbs_status_monitor mon_u (.*);

// ### dv/sbs_status_regs_tb.sv
// Purpose: bench; Assumes: answer one cycle after the read edge
// Notes: inputs move 1 ns after the rising edge
`timescale 1ns/10ps
module sbs_status_regs_tb import sbs_pkg::*; ;
   logic        clk_sys_i = 1'h0, resetn_i = 1'h0, rd_en_i = 1'h0, cp = 1'h0;
   logic        rd_hit_o;
   logic [6:0]  rd_addr_i = 7'h00;
   logic [15:0] rd_data_o, v;
   logic [3:0]  ot = 4'h0, ol = 4'h0, oc = 4'h0, ns = 4'h0, pwm = 4'h0;
   logic [7:0]  mode = 8'h00;
   logic [3:0]  sot, sol, soc;
   logic [16:0] w;
   int          fails = 0, comparisons = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   sbs_status_regs dut_u (.clk_sys_i, .resetn_i, .rd_en_i, .rd_addr_i,
      .rd_data_o, .rd_hit_o, .overtemp_evt_i(ot), .openload_evt_i(ol),
      .overcurrent_evt_i(oc), .bridge_near_supply_i(ns),
      .bridge_mode_field_i(mode), .charge_pump_enable_i(cp),
      .pwm_input_level_i(pwm), .switch_overtemp_flag_o(sot),
      .switch_openload_flag_o(sol), .switch_overcurrent_flag_o(soc));
   task automatic check(input string name, input logic [16:0] seen,
                        input logic [16:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input string name, input logic [6:0] a,
                     input logic [16:0] e);
      {rd_en_i, rd_addr_i} = {1'h1, a};
      @(posedge clk_sys_i) #1;
      check(name, {rd_hit_o, rd_data_o}, e);
   endtask
   task automatic stop_test;
      $display("%0d comparisons %0d fails", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_i);
      #1 resetn_i = 1'h1;
      rd("unmapped", 7'h47, 17'h00000);
      for (int n = 0; n < 4; n++) begin
         {ot, ol, oc} = {4'h1 << n, 4'h8 >> n, 4'h3 << n};
         v = {2'h0, ot, 1'h0, ol, 1'h0, oc};
         w = {5'h00, ot, ol, oc};
         rd("fault pre", SBS_ADDR_HS_FLT, 17'h10000);
         check("flags", {5'h00, sot, sol, soc}, w);
         {ot, ol, oc} = 12'h000;
         rd("fault", SBS_ADDR_HS_FLT, {1'h1, v});
         check("clear", {5'h00, sot, sol, soc}, 17'h00000);
      end
      for (int k = 0; k < 8; k++) begin
         {cp, mode} = {k[2], {4{k[1:0]}}};
         {ns, pwm} = {4'hF ^ k[3:0], k[3:0] * 4'h3};
         v = {12'h000, pwm};
         for (int n = 0; n < 4; n++)
            v[n + 6] = cp && mode[2*n+:2] == SBS_MODE_ACTIVE && ns[n];
         rd("general", SBS_ADDR_GEN, {1'h1, v});
      end
      {cp, mode, ns, pwm} = {1'h1, 8'hC3, 4'hF, 4'hA};
      rd("mixed modes", SBS_ADDR_GEN, 17'h1024A);
      rd_en_i = 1'h0;
      @(posedge clk_sys_i) #1;
      check("idle", {rd_hit_o, rd_data_o}, 17'h0024A);
      ot = 4'hF;
      @(posedge clk_sys_i) #1;
      ot = 4'h0;
      resetn_i = 1'h0;
      check("flags", {5'h00, sot, sol, soc}, 17'h00F00);
      repeat (2) @(posedge clk_sys_i);
      #1 resetn_i = 1'h1;
      check("reset", {5'h00, sot, sol, soc}, 17'h00000);
      check("reset data", {rd_hit_o, rd_data_o}, 17'h00000);
      rd("after reset", SBS_ADDR_HS_FLT, 17'h10000);
      rd_en_i = 1'h0;
      stop_test();
   end
endmodule
